// File: pkg/edc_defines.svh
`ifndef EDC_DEFINES_SVH
`define EDC_DEFINES_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define EDC_ADDR_W        10
`define EDC_DATA_W        16
`define EDC_ROWS          1024
`define EDC_INIT_CYCLES   8

// ----------------------------------------------------------------
// Timing in ns, refresh period in ms, power-up pause in us (slowest grade used as default)
// ----------------------------------------------------------------
`define EDC_CLK_NS        10
`define EDC_TRAS_NS       60
`define EDC_TRP_NS        40
`define EDC_TCAC_NS       15
`define EDC_TAA_NS        30
`define EDC_TRAC_NS       60
`define EDC_TPC_NS        25
`define EDC_TRC_NS        104
`define EDC_TRCD_NS       20
`define EDC_TCP_NS        10
`define EDC_REF_MS        16
`define EDC_PWRUP_US      200

// ----------------------------------------------------------------
// Derived cycle counts (minimums round up)
// ----------------------------------------------------------------
`define EDC_CYC_UP(ns)    (((ns) + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_TRAS_CYC      `EDC_CYC_UP(`EDC_TRAS_NS)
`define EDC_TRP_CYC       `EDC_CYC_UP(`EDC_TRP_NS)
`define EDC_TRCD_CYC      `EDC_CYC_UP(`EDC_TRCD_NS)
`define EDC_TCAS_CYC      `EDC_CYC_UP(`EDC_TRAC_NS - `EDC_TRCD_NS)
`define EDC_TCP_CYC       `EDC_CYC_UP(`EDC_TCP_NS)
`define EDC_TRC_CYC       `EDC_CYC_UP(`EDC_TRC_NS)
// Refresh interval per row rounds down (a longest time)
`define EDC_REFI_CYC      ((`EDC_REF_MS * 1000000) / `EDC_ROWS / `EDC_CLK_NS)
`define EDC_PWRUP_CYC     (`EDC_PWRUP_US * 1000 / `EDC_CLK_NS)

`endif

// File: pkg/edc_pkg.sv
package edc_pkg;

    // Controller sequencer states
    typedef enum logic [3:0] {
        ST_PWRUP,
        ST_INIT,
        ST_IDLE,
        ST_ROW,
        ST_RCD,
        ST_COL,
        ST_CPRE,
        ST_RAS_HOLD,
        ST_CBR_CAS,
        ST_CBR_RAS,
        ST_PRE
    } edc_state_e;

    typedef logic [15:0] edc_cnt_t;

endpackage : edc_pkg

// File: rtl/edc_timer.sv
`timescale 1ns/100ps
`include "edc_defines.svh"

// Down counter used for strobe timing except the row active minimum
module edc_timer
#(
    parameter int W = 16
)
(
    // Clock and reset
    input  wire logic         CLOCK,
    input  wire logic         RST,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    // Status
    output logic              done
);

    logic [W-1:0] cnt_r;    // Remaining cycles

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            cnt_r <= '0;
        else if (load)
            cnt_r <= value;
        else if (cnt_r != '0)
            cnt_r <= cnt_r - W'(1);
    end

    // Done once the count has run out
    assign done = (cnt_r == '0);

endmodule : edc_timer

// File: rtl/edc_ctrl.sv
`timescale 1ns/100ps
`include "edc_defines.svh"

module edc_ctrl
#(
    parameter int PWRUP_CYC = `EDC_PWRUP_CYC,
    parameter int REFI_CYC  = `EDC_REFI_CYC
)
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST,
    // User request
    input  wire logic        REQ_VALID,
    input  wire logic        REQ_WRITE,
    input  wire logic [19:0] REQ_ADDR,
    input  wire logic [1:0]  REQ_BE,
    input  wire logic [15:0] REQ_WDATA,
    input  wire logic        REQ_PAGE,
    output logic             REQ_READY,
    // User read answer
    output logic             RSP_VALID,
    output logic [15:0]      RSP_RDATA,
    output logic             INIT_DONE,
    // Memory pins
    output logic             ROW_STROBE_N,
    output logic             LOW_BYTE_COL_STROBE_N,
    output logic             HIGH_BYTE_COL_STROBE_N,
    output logic             WRITE_SELECT_N,
    output logic             OUTPUT_GATE_N,
    output logic [9:0]       ADDR,
    input  wire logic [15:0] DQ_IN,
    output logic [15:0]      DQ_OUT,
    output logic [15:0]      DQ_OE
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    edc_pkg::edc_state_e st_r, st_nxt;     // Sequencer state
    logic [15:0]  t_val;                   // Timer load value
    logic         t_load;                  // Timer load strobe
    logic         t_done;                  // Timer expired
    logic [15:0]  ras_cnt_r;               // Cycles row strobe low
    logic [15:0]  ref_cnt_r;               // Refresh interval counter
    logic         ref_pend_r;              // Refresh owed
    logic [3:0]   init_cnt_r;              // Init cycles issued
    logic [9:0]   open_row_r;              // Row currently open
    logic         wr_r;                    // Current access is write
    logic [1:0]   be_r;                    // Current byte lanes
    logic [9:0]   col_r;                   // Current column
    logic [15:0]  wd_r;                    // Current write data
    logic         ras_r, low_byte_col_strobe_r, high_byte_col_strobe_r;   // Strobe registers, active high
    logic         we_r, oe_r;              // Write and gate, active high
    logic [9:0]   addr_r;                  // Address pins
    logic         rv_r;                    // Read answer pulse
    logic [15:0]  rd_r;                    // Read answer data
    logic         rdy_r;                   // Ready register
    logic         idone_r;                 // Init done register
    logic         ras_ok;                  // Row active minimum met
    logic         page_hit;                // Request may stay in row
    logic         take;                    // Request accepted
    logic         ref_due;                 // Refresh interval elapsed
    logic         pwr_first_r;             // First cycle after reset
    logic         pwr_load;                // Load power-up pause
    logic [15:0]  pwr_val;                 // Power-up pause value

    // ----------------------------------------------------------------
    // Timing helpers
    // ----------------------------------------------------------------
    assign ras_ok   = (ras_cnt_r >= 16'(`EDC_TRAS_CYC));
    assign page_hit = REQ_PAGE && (REQ_ADDR[19:10] == open_row_r);
    assign take     = REQ_VALID && rdy_r;
    assign ref_due  = (ref_cnt_r == 16'(REFI_CYC - 1));
    assign pwr_load = pwr_first_r;
    assign pwr_val  = 16'(PWRUP_CYC);

    edc_timer #(.W(16)) u_timer
    (
        .CLOCK (CLOCK),
        .RST   (RST),
        .load  (t_load),
        .value (t_val),
        .done  (t_done)
    );

    // ----------------------------------------------------------------
    // Next state and timer loads
    // ----------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        t_load = 1'b0;
        t_val  = '0;
        case (st_r)
            edc_pkg::ST_PWRUP:
                if (pwr_load)
                begin
                    t_load = 1'b1;                      // Start the power-up pause
                    t_val  = pwr_val;
                end
                else if (t_done)
                    st_nxt = edc_pkg::ST_CBR_CAS;
            edc_pkg::ST_IDLE:                           // Precharge met in ST_PRE
                if (take)
                    st_nxt = edc_pkg::ST_ROW;           // Only a captured request opens a row
                else if (ref_pend_r || !idone_r)
                    st_nxt = edc_pkg::ST_CBR_CAS;
            edc_pkg::ST_ROW:                            // Row address out; row strobe falls entering ST_RCD
            begin
                st_nxt = edc_pkg::ST_RCD;
                t_load = 1'b1;
                t_val  = 16'(`EDC_TRCD_CYC - 1);
            end
            edc_pkg::ST_RCD:                            // row to column
                if (t_done)
                begin
                    st_nxt = edc_pkg::ST_COL;
                    t_load = 1'b1;
                    t_val  = 16'(`EDC_TCAS_CYC - 1);
                end
            edc_pkg::ST_COL:
                if (t_done)
                begin
                    st_nxt = edc_pkg::ST_CPRE;
                    t_load = 1'b1;
                    t_val  = 16'(`EDC_TCP_CYC - 1);
                end
            edc_pkg::ST_CPRE:
                if (t_done)
                begin
                    if (take)
                        st_nxt = edc_pkg::ST_RCD;       // gap cycle loads new column
                    else
                        st_nxt = edc_pkg::ST_RAS_HOLD;
                    t_load = 1'b1;
                    t_val  = '0;
                end
            edc_pkg::ST_RAS_HOLD:
                if (ras_ok)
                begin
                    st_nxt = edc_pkg::ST_PRE;
                    t_load = 1'b1;
                    t_val  = 16'(`EDC_TRC_CYC - `EDC_TRAS_CYC);
                end
            edc_pkg::ST_CBR_CAS:                        // column first
            begin
                st_nxt = edc_pkg::ST_CBR_RAS;
            end
            edc_pkg::ST_CBR_RAS:
                if (ras_ok)
                begin
                    st_nxt = edc_pkg::ST_PRE;
                    t_load = 1'b1;
                    t_val  = 16'(`EDC_TRC_CYC - `EDC_TRAS_CYC);
                end
            edc_pkg::ST_PRE:
                if (t_done)
                    st_nxt = edc_pkg::ST_IDLE;
            default:
                st_nxt = edc_pkg::ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // State register and first-cycle flag
    // ----------------------------------------------------------------

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            st_r        <= edc_pkg::ST_PWRUP;
            pwr_first_r <= 1'b1;
        end
        else
        begin
            st_r        <= st_nxt;
            pwr_first_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Row active and refresh counters
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            ras_cnt_r  <= '0;
            ref_cnt_r  <= '0;
            ref_pend_r <= 1'b0;
            init_cnt_r <= '0;
        end
        else
        begin
            ras_cnt_r <= ras_r ? ras_cnt_r + 16'(1) : '0;
            ref_cnt_r <= ref_due ? '0 : ref_cnt_r + 16'(1);
            if (ref_due)
                ref_pend_r <= 1'b1;                         // Set wins over clear
            else if (st_r == edc_pkg::ST_CBR_CAS && idone_r)
                ref_pend_r <= 1'b0;
            if (st_r == edc_pkg::ST_CBR_CAS && !idone_r)
                init_cnt_r <= init_cnt_r + 4'(1);
        end
    end

    // ----------------------------------------------------------------
    // Request capture
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            wr_r       <= 1'b0;
            be_r       <= '0;
            col_r      <= '0;
            wd_r       <= '0;
            open_row_r <= '0;
        end
        else if (take)
        begin
            wr_r       <= REQ_WRITE;
            be_r       <= REQ_BE;
            col_r      <= REQ_ADDR[9:0];
            wd_r       <= REQ_WDATA;
            open_row_r <= REQ_ADDR[19:10];
        end
    end

    // Ready in idle and at column precharge for page hits
    assign REQ_READY = rdy_r;

    // ----------------------------------------------------------------
    // Pin registers
    // ----------------------------------------------------------------
    logic col_phase;   // Column strobe active from the next cycle
    assign col_phase = (st_nxt == edc_pkg::ST_COL);

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            ras_r   <= 1'b0;
            low_byte_col_strobe_r  <= 1'b0;
            high_byte_col_strobe_r  <= 1'b0;
            we_r    <= 1'b0;
            oe_r    <= 1'b0;
            addr_r  <= '0;
            rv_r    <= 1'b0;
            rd_r    <= '0;
            rdy_r   <= 1'b0;
            idone_r <= 1'b0;
        end
        else
        begin
            ras_r  <= (st_nxt inside {edc_pkg::ST_RCD, edc_pkg::ST_COL, edc_pkg::ST_CPRE,
                      edc_pkg::ST_RAS_HOLD, edc_pkg::ST_CBR_RAS, edc_pkg::ST_ROW})
                      && st_nxt != edc_pkg::ST_ROW || st_nxt == edc_pkg::ST_CBR_RAS;
            low_byte_col_strobe_r <= (col_phase && be_r[0]) ||
                      (st_nxt inside {edc_pkg::ST_CBR_CAS, edc_pkg::ST_CBR_RAS});
            high_byte_col_strobe_r <= (col_phase && be_r[1]) ||
                      (st_nxt inside {edc_pkg::ST_CBR_CAS, edc_pkg::ST_CBR_RAS});
            we_r   <= col_phase && wr_r;
            oe_r   <= col_phase && !wr_r;
            if (st_nxt == edc_pkg::ST_ROW || st_nxt == edc_pkg::ST_RCD)
                addr_r <= open_row_r;
            else if (st_nxt == edc_pkg::ST_COL)
                addr_r <= col_r;
            rv_r <= (st_r == edc_pkg::ST_COL) && t_done && !wr_r;
            if ((st_r == edc_pkg::ST_COL) && t_done && !wr_r)
                rd_r <= DQ_IN;
            rdy_r <= !rdy_r && ((st_nxt == edc_pkg::ST_IDLE && !ref_pend_r && idone_r)
                     || (st_nxt == edc_pkg::ST_CPRE && REQ_VALID && page_hit
                         && !ref_pend_r));
            if (init_cnt_r >= 4'(`EDC_INIT_CYCLES))
                idone_r <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Write data drive: only during write columns
    // ----------------------------------------------------------------
    logic [15:0] dq_o_r;   // Data out register
    logic [15:0] dq_e_r;   // Lane enables
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            dq_o_r <= '0;
            dq_e_r <= '0;
        end
        else
        begin
            dq_o_r <= wd_r;
            dq_e_r <= {{8{col_phase && wr_r && be_r[1]}},
                       {8{col_phase && wr_r && be_r[0]}}};
        end
    end

    // ----------------------------------------------------------------
    // Output assignments
    // ----------------------------------------------------------------
    assign ROW_STROBE_N           = !ras_r;
    assign LOW_BYTE_COL_STROBE_N  = !low_byte_col_strobe_r;
    assign HIGH_BYTE_COL_STROBE_N = !high_byte_col_strobe_r;
    assign WRITE_SELECT_N         = !we_r;
    assign OUTPUT_GATE_N          = !oe_r;
    assign ADDR                   = addr_r;
    assign DQ_OUT                 = dq_o_r;
    assign DQ_OE                  = dq_e_r;
    assign RSP_VALID              = rv_r;
    assign RSP_RDATA              = rd_r;
    assign INIT_DONE              = idone_r;

endmodule : edc_ctrl

// File: testbench/edc_ctrl_checker.sv
`timescale 1ns/100ps
// ------------------------------------------------
// Pin timing checker for the controller
// ------------------------------------------------
module edc_ctrl_checker
#(
    parameter int PWRUP_CYC = 20000
)
(
    // Clock and reset
    input wire logic        CLOCK,
    input wire logic        RST,
    // Memory pins
    input wire logic        ROW_STROBE_N,
    input wire logic        LOW_BYTE_COL_STROBE_N,
    input wire logic        HIGH_BYTE_COL_STROBE_N,
    input wire logic        WRITE_SELECT_N,
    input wire logic        OUTPUT_GATE_N,
    input wire logic [9:0]  ADDR,
    input wire logic [15:0] DQ_OE,
    // Status
    input wire logic        INIT_DONE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    logic        ras_q_r;   // Row strobe one cycle back
    logic        cas_q_r;   // Combined strobe one cycle back
    logic [7:0]  ras_gap_r; // Cycles since row strobe fell
    logic [15:0] up_cnt_r;  // Cycles since reset
    logic [3:0]  falls_r;   // Row strobe falls since reset
    wire cas_n    = LOW_BYTE_COL_STROBE_N & HIGH_BYTE_COL_STROBE_N;
    wire ras_fell = ras_q_r & ~ROW_STROBE_N;
    wire cas_fell = cas_q_r & ~cas_n;
    // Edge history and saturating counters
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            ras_q_r   <= 1'b1;
            cas_q_r   <= 1'b1;
            ras_gap_r <= 8'hff;
            up_cnt_r  <= 16'h0;
            falls_r   <= 4'h0;
        end
        else
        begin
            ras_q_r   <= ROW_STROBE_N;
            cas_q_r   <= cas_n;
            ras_gap_r <= ras_fell ? 8'h01 : ras_gap_r + {7'h0, ras_gap_r != 8'hff};
            up_cnt_r  <= up_cnt_r + {15'h0, up_cnt_r != 16'hffff};
            falls_r   <= falls_r + {3'h0, ras_fell && falls_r != 4'hf};
        end
    end
    AST_RAS_MIN_LOW: assert property ($fell(ROW_STROBE_N) |-> !ROW_STROBE_N [*6])
        else $error("Row strobe released too early");
    AST_PRECHARGE: assert property ($rose(ROW_STROBE_N) |-> ROW_STROBE_N [*4])
        else $error("Precharge too short");
    AST_CYCLE_GAP: assert property (ras_fell |-> ras_gap_r >= 8'h0b)
        else $error("Row cycles too close");
    AST_CBR_ORDER: assert property ($fell(ROW_STROBE_N) |->
        $stable(LOW_BYTE_COL_STROBE_N) && $stable(HIGH_BYTE_COL_STROBE_N))
        else $error("Column strobe moved at row strobe fall");
    AST_ROW_FIRST: assert property (cas_fell && !ROW_STROBE_N |-> !$past(ROW_STROBE_N, 2))
        else $error("Column strobe too soon after row strobe");
    AST_COL_HOLD: assert property (cas_fell && !ROW_STROBE_N |=> $stable(ADDR))
        else $error("Column address not held");
    AST_WDATA_LOW: assert property ($fell(LOW_BYTE_COL_STROBE_N) && !ROW_STROBE_N
        && !WRITE_SELECT_N |-> DQ_OE[7:0] == 8'hff) else $error("Low write data late");
    AST_WDATA_HIGH: assert property ($fell(HIGH_BYTE_COL_STROBE_N) && !ROW_STROBE_N
        && !WRITE_SELECT_N |-> DQ_OE[15:8] == 8'hff) else $error("High write data late");
    AST_GATE_READ: assert property (!OUTPUT_GATE_N |-> WRITE_SELECT_N && DQ_OE == 16'h0)
        else $error("Gate low while writing or driving");
    AST_PWRUP: assert property (ras_fell |-> up_cnt_r >= PWRUP_CYC)
        else $error("Row strobe during power-up pause");
    AST_INIT_CNT: assert property ($rose(INIT_DONE) |-> falls_r >= 4'h8)
        else $error("Ready before eight init cycles");
    COV_READ: cover property ($fell(OUTPUT_GATE_N));
    COV_WRITE: cover property (cas_fell && !WRITE_SELECT_N);
    COV_REFRESH: cover property (ras_fell && !cas_n);
endmodule : edc_ctrl_checker

bind edc_ctrl edc_ctrl_checker #(.PWRUP_CYC(PWRUP_CYC)) i_edc_ctrl_checker (
    .CLOCK(CLOCK), .RST(RST), .ROW_STROBE_N(ROW_STROBE_N),
    .LOW_BYTE_COL_STROBE_N(LOW_BYTE_COL_STROBE_N),
    .HIGH_BYTE_COL_STROBE_N(HIGH_BYTE_COL_STROBE_N), .WRITE_SELECT_N(WRITE_SELECT_N),
    .OUTPUT_GATE_N(OUTPUT_GATE_N), .ADDR(ADDR), .DQ_OE(DQ_OE), .INIT_DONE(INIT_DONE));

// File: testbench/edc_mem_model.sv
`timescale 1ns/100ps
// Behavioural memory device on the far side
module edc_mem_model
(
    // Controller pins
    input wire logic        ras_n,
    input wire logic        low_byte_col_strobe_n,
    input wire logic        hcas_n,
    input wire logic        we_n,
    input wire logic        oe_n,
    input wire logic [9:0]  addr,
    input wire logic [15:0] dq_out,
    input wire logic [15:0] dq_oe,
    // Data back and tallies
    output logic [15:0]     dq_in,
    output int              cbr_count,
    output int              wr_fault
);
    logic [15:0] mem [bit [19:0]]; // Word store, never decays
    logic [9:0]  row_r;            // Open row
    logic [15:0] rd_r = 16'h0;     // Last word fetched
    logic [1:0]  on_r = 2'b00;     // Lanes inside read window
    logic [15:0] w;                // Word being accessed
    wire         cas_n = low_byte_col_strobe_n & hcas_n; // Combined strobe
    initial
    begin
        cbr_count = 0;
        wr_fault = 0;
    end
    // Row capture, or refresh when a column strobe leads
    always @(negedge ras_n)
    begin
        #1;
        if (cas_n)
            row_r = addr;
        else
            cbr_count++;
    end
    always @(posedge ras_n) on_r = 2'b00;
    always @(negedge low_byte_col_strobe_n) #1 lane(0);
    always @(negedge hcas_n) #1 lane(1);
    // One lane access within the open row
    task lane(input int h);
        w = mem.exists({row_r, addr}) ? mem[{row_r, addr}] : 16'h0;
        if (!ras_n && !we_n)
        begin
            if (dq_oe[h*8 +: 8] !== 8'hff)
                wr_fault++;
            w[h*8 +: 8] = dq_out[h*8 +: 8];
            mem[{row_r, addr}] = w;
        end
        else if (!ras_n)
        begin
            on_r[h] = 1'b1;
            rd_r[h*8 +: 8] <= #15 w[h*8 +: 8];
        end
    endtask : lane
    // Released lanes show the inverse of the last value
    assign dq_in[7:0]  = on_r[0] && !oe_n && we_n ? rd_r[7:0] : ~rd_r[7:0];
    assign dq_in[15:8] = on_r[1] && !oe_n && we_n ? rd_r[15:8] : ~rd_r[15:8];
endmodule : edc_mem_model

// File: testbench/edo_dram_interface_bench.sv
`timescale 1ns/100ps
module edo_dram_interface_bench;
    localparam int PWRUP = 10;  // Shortened power-up pause
    localparam int REFI  = 200; // Shortened refresh interval
    logic        clock, rst = 1, req_valid = 0, req_write = 0, req_page = 0;
    logic        req_ready, rsp_valid, init_done, ras_n, low_byte_col_strobe_n, hcas_n, we_n, oe_n;
    logic [19:0] req_addr = 0;
    logic [1:0]  req_be = 0;
    logic [15:0] req_wdata = 0, rsp_rdata, dq_in, dq_out, dq_oe;
    logic [9:0]  addr;
    int          n_mismatch = 0, n_checks = 0, cycles = 0, cbr_count, wr_fault, base = 0;
    edc_ctrl #(.PWRUP_CYC(PWRUP), .REFI_CYC(REFI)) i_edc_ctrl (
        .CLOCK(clock), .RST(rst), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
        .REQ_ADDR(req_addr), .REQ_BE(req_be), .REQ_WDATA(req_wdata), .REQ_PAGE(req_page),
        .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
        .INIT_DONE(init_done), .ROW_STROBE_N(ras_n), .LOW_BYTE_COL_STROBE_N(low_byte_col_strobe_n),
        .HIGH_BYTE_COL_STROBE_N(hcas_n), .WRITE_SELECT_N(we_n), .OUTPUT_GATE_N(oe_n),
        .ADDR(addr), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe));
    edc_mem_model i_edc_mem_model (
        .ras_n(ras_n), .low_byte_col_strobe_n(low_byte_col_strobe_n), .hcas_n(hcas_n), .we_n(we_n), .oe_n(oe_n),
        .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
        .cbr_count(cbr_count), .wr_fault(wr_fault));
    // Clock generator
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Compare and tally
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Bounded wait for a flag sampled at the edge
    task automatic wait_high(ref logic s, input int lim, input string what);
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (s !== 1'b1 && n < lim);
        chk(what, 16'h1, {15'h0, s});
    endtask : wait_high
    // One request held until taken
    task automatic send(input logic wr, input logic [19:0] a, input logic [1:0] be,
                        input logic [15:0] wd, input logic pg);
        @(posedge clock) #1;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_be = be;
        req_wdata = wd;
        req_page = pg;
        wait_high(req_ready, 80, "request taken");
        #1;
        req_valid = 1'b0;
    endtask : send
    // Read and compare
    task automatic fetch(input logic [19:0] a, input logic pg, input logic [15:0] exp);
        send(1'b0, a, 2'b11, 16'h0, pg);
        wait_high(rsp_valid, 60, "read answer");
        chk("read data", exp, rsp_rdata);
    endtask : fetch
    // Power-up pause and init refresh burst
    task automatic t_init();
        wait_high(init_done, 400, "init done");
        chk("init refreshes", 16'h1, {15'h0, cbr_count - base >= 8});
    endtask : t_init
    // Words at both ends of the space, then byte lanes
    task automatic t_rw();
        send(1'b1, 20'h00000, 2'b11, 16'ha5c3, 1'b0);
        send(1'b1, 20'hfffff, 2'b11, 16'h5a3c, 1'b0);
        fetch(20'h00000, 1'b0, 16'ha5c3);
        fetch(20'hfffff, 1'b0, 16'h5a3c);
        send(1'b1, 20'h12345, 2'b11, 16'h1111, 1'b0);
        send(1'b1, 20'h12345, 2'b01, 16'hff22, 1'b0);
        send(1'b1, 20'h12345, 2'b10, 16'h33ff, 1'b0);
        fetch(20'h12345, 1'b0, 16'h3322);
    endtask : t_rw
    // Page hits across the first and last column
    task automatic t_page();
        send(1'b1, 20'ha8c00, 2'b11, 16'h0f0f, 1'b1);
        send(1'b1, 20'ha8c01, 2'b11, 16'hf0f0, 1'b1);
        send(1'b1, 20'ha8fff, 2'b11, 16'h8001, 1'b1);
        fetch(20'ha8c00, 1'b1, 16'h0f0f);
        fetch(20'ha8c01, 1'b1, 16'hf0f0);
        fetch(20'ha8fff, 1'b0, 16'h8001);
    endtask : t_page
    // Idle spell: bus released, refresh keeps running
    task automatic t_idle();
        int bad;
        bad = 0;
        base = cbr_count;
        repeat (REFI + 80)
        begin
            @(posedge clock);
            if (dq_oe !== 16'h0)
                bad++;
        end
        chk("idle drive", 16'h0, bad[15:0]);
        chk("idle refresh", 16'h1, {15'h0, cbr_count > base});
        chk("late write data", 16'h0, wr_fault[15:0]);
    endtask : t_idle
    // Reset in mid-run, data kept by the device
    task automatic t_reset();
        @(posedge clock) #1;
        rst = 1'b1;
        repeat (3) @(posedge clock);
        chk("strobes in reset", 16'h7, {13'h0, ras_n, low_byte_col_strobe_n, hcas_n});
        chk("bus in reset", 16'h0, dq_oe);
        #1;
        rst = 1'b0;
        base = cbr_count;
        t_init();
        fetch(20'h12345, 1'b0, 16'h3322);
    endtask : t_reset
    // Verdict and end of run
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up
    // Hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end
    // Main sequence
    initial
    begin
        repeat (10) @(posedge clock);
        #1;
        rst = 1'b0;
        t_init();
        t_rw();
        t_page();
        t_idle();
        t_reset();
        wrap_up();
    end
endmodule : edo_dram_interface_bench
